// File: design/ccdsm_pkg.sv
// Constants, types and field layout for the CCD sample and multiplex sequencer
package ccdsm_pkg;

  // Register byte offsets
  localparam logic [7:0] CCDSM_A_S1W1 = 8'h00;
  localparam logic [7:0] CCDSM_A_S1W2 = 8'h04;
  localparam logic [7:0] CCDSM_A_S2W1 = 8'h08;
  localparam logic [7:0] CCDSM_A_S2W2 = 8'h0c;
  localparam logic [7:0] CCDSM_A_DAC_R = 8'h10;
  localparam logic [7:0] CCDSM_A_DAC_G = 8'h14;
  localparam logic [7:0] CCDSM_A_DAC_B = 8'h18;
  localparam logic [7:0] CCDSM_A_CTRL = 8'h1c;
  localparam logic [7:0] CCDSM_A_STATUS = 8'h20;
  localparam logic [7:0] CCDSM_A_LAST = 8'h24;

  // Values after reset
  localparam logic [7:0] CCDSM_S1W1_RST = 8'h00;
  localparam logic [7:0] CCDSM_S1W2_RST = 8'h80;
  localparam logic [7:0] CCDSM_S2_RST = 8'h00;
  localparam logic [8:0] CCDSM_DAC_RST = 9'h000;
  localparam logic [7:0] CCDSM_CTRL_RST = 8'h00;

  // Field positions and codes
  localparam int CCDSM_S1W2_CDS_BIT = 0;
  localparam int CCDSM_S1W2_MONO_BIT = 4;
  localparam logic [7:0] CCDSM_MAXMONO_CODE = 8'h5d;
  localparam int CCDSM_CTRL_DIFF_BIT = 0;
  localparam int CCDSM_CTRL_INV_BIT = 1;
  localparam int CCDSM_CTRL_STBY_BIT = 2;
  localparam int CCDSM_CTRL_SHIFT_LSB = 4;
  localparam int CCDSM_DAC_SIGN_BIT = 8;
  localparam int CCDSM_DAC_SCALE_SH = 3;

  // Widths, history depth and converter codes
  localparam int CCDSM_CODE_W = 12;
  localparam int CCDSM_HIST_DEPTH = 4;
  localparam logic [1:0] CCDSM_LAST_COLOR = 2'h2;
  localparam logic signed [15:0] CCDSM_MID_CODE = 16'sh0800;
  localparam logic signed [15:0] CCDSM_MAX_CODE = 16'sh0fff;

  typedef enum logic [1:0] {
    CCDSM_COLOR = 2'b00,
    CCDSM_MONO = 2'b01,
    CCDSM_MAXMONO = 2'b10
  } ccdsm_mode_t;

  typedef enum logic [1:0] {
    CCDSM_IDLE = 2'b00,
    CCDSM_RUN = 2'b01
  } ccdsm_state_t;

  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic signed [15:0] level;
  } ccdsm_req_t;

  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic [11:0] code;
  } ccdsm_res_t;

endpackage : ccdsm_pkg

// File: design/ccdsm_converter.sv
// Pipelined converter model: one result per two clocks, clamp, invert, standby
`timescale 1ns/1ps
`default_nettype none
module ccdsm_converter
  import ccdsm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic conv_en,
  input wire logic standby,
  input wire logic invert,
  input wire ccdsm_req_t req,
  output ccdsm_res_t res
);

  ccdsm_req_t stage_q;
  logic signed [15:0] biased;
  logic [11:0] code;

  // Offset binary with clamping at both ends
  always_comb begin
    biased = stage_q.level + CCDSM_MID_CODE;
    if (biased < 16'sh0000) begin
      code = 12'h000;
    end else if (biased > CCDSM_MAX_CODE) begin
      code = 12'hfff;
    end else begin
      code = biased[11:0];
    end
  end

  // First pipeline stage takes one sample per conversion slot
  always_ff @(posedge clk) begin
    if (rst || standby) begin
      stage_q <= '0;
    end else if (conv_en) begin
      stage_q <= req;
    end
  end

  // Result leaves one slot later; standby freezes the code, drops valid
  always_ff @(posedge clk) begin
    if (rst) begin
      res <= '0;
    end else if (standby) begin
      res.valid <= 1'b0;
    end else begin
      res.valid <= conv_en & stage_q.valid;
      if (conv_en && stage_q.valid) begin
        res.chan <= stage_q.chan;
        res.code <= invert ? ~code : code;
      end
    end
  end

endmodule : ccdsm_converter
`default_nettype wire

// File: design/ccdsm_sequencer.sv
// Top: APB registers, sample and hold, channel multiplexer and sequencing
`timescale 1ns/1ps
`default_nettype none
module ccdsm_sequencer
  import ccdsm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic video_sample_pulse,
  input wire logic [35:0] ch_level,
  output logic [11:0] conv_code,
  output logic [1:0] conv_chan,
  output logic conv_valid,
  output logic diff_mode
);

  // Register state
  logic [7:0] s1w1_q;
  logic [7:0] s1w2_q;
  logic [7:0] s2w1_q;
  logic [7:0] s2w2_q;
  logic [2:0][8:0] dac_q;
  logic [7:0] ctrl_q;
  logic [11:0] last_code_q;
  logic [15:0] conv_cnt_q;

  // Sequencer state
  ccdsm_state_t state_q;
  ccdsm_mode_t mode;
  logic [1:0] seq_q;
  logic div_q;
  logic pulse_q;
  logic [CCDSM_HIST_DEPTH-1:0][35:0] hist_q;
  logic [2:0][15:0] hold_q;
  logic cds;
  logic invert;
  logic standby;
  logic [1:0] shift;
  logic [1:0] mono_ch;
  logic conv_en;
  logic capture;
  ccdsm_req_t req;
  ccdsm_res_t res;

  // APB decode helpers
  logic wr_en;
  logic rd_setup;
  logic mapped;

  // Signed channel level from packed input bus
  function automatic logic signed [11:0] ch_of(input logic [35:0] bus, input logic [1:0] ch);
    logic [11:0] v;
    v = bus[12*ch +: 12];
    return $signed(v);
  endfunction : ch_of

  // Front end gain and offset DAC, shared by every channel path
  function automatic logic signed [15:0] front_end(
    input logic signed [12:0] diff_in,
    input logic [8:0] dac,
    input logic differential
  );
    logic signed [15:0] x;
    logic signed [15:0] mag;
    x = 16'(diff_in);
    // Single-ended input carries a gain of two
    if (!differential) begin
      x = x <<< 1;
    end
    mag = 16'({dac[7:0], 3'b000});
    // Sign-magnitude correction code
    if (dac[CCDSM_DAC_SIGN_BIT]) begin
      x = x - mag;
    end else begin
      x = x + mag;
    end
    return x;
  endfunction : front_end

  // Reset-sample position picked out of the input history
  function automatic logic [1:0] lag_index(input logic [1:0] sh);
    case (sh)
      2'b00: return 2'd2;
      2'b01: return 2'd3;
      2'b10: return 2'd1;
      2'b11: return 2'd0;
      default: return 2'd2;
    endcase
  endfunction : lag_index

  // Operating mode from the setup words
  always_comb begin
    if (s1w1_q == CCDSM_MAXMONO_CODE) begin
      mode = CCDSM_MAXMONO;
    end else if (s1w2_q[CCDSM_S1W2_MONO_BIT]) begin
      mode = CCDSM_MONO;
    end else begin
      mode = CCDSM_COLOR;
    end
  end

  // Max-speed mono never runs double sampling
  assign cds = s1w2_q[CCDSM_S1W2_CDS_BIT] & (mode != CCDSM_MAXMONO);
  assign diff_mode = ctrl_q[CCDSM_CTRL_DIFF_BIT];
  assign invert = ctrl_q[CCDSM_CTRL_INV_BIT];
  assign standby = ctrl_q[CCDSM_CTRL_STBY_BIT];
  assign shift = ctrl_q[CCDSM_CTRL_SHIFT_LSB +: 2];
  // Code 3 has no input behind it, so it folds onto blue
  assign mono_ch = (s2w2_q[1:0] == 2'b11) ? 2'b10 : s2w2_q[1:0];

  // Sampling happens on the first edge after the pulse was seen
  assign capture = pulse_q;
  assign conv_en = ~div_q;

  // Pulse register and input history for the reset-level sample
  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_q <= 1'b0;
      hist_q <= '0;
    end else begin
      pulse_q <= video_sample_pulse;
      hist_q <= {hist_q[CCDSM_HIST_DEPTH-2:0], ch_level};
    end
  end

  // Divider realigned on color pulses only; an odd mono ratio would
  // otherwise give two conversions in adjacent clocks
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= 1'b0;
    end else if (capture && (mode == CCDSM_COLOR)) begin
      div_q <= 1'b0;
    end else begin
      div_q <= ~div_q;
    end
  end

  // Sample and hold for all three channels at the same instant
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_q <= '0;
    end else if (capture) begin
      for (int c = 0; c < 3; c++) begin
        if (cds) begin
          // Video minus reset level feeds the converter
          hold_q[c] <= front_end(13'(ch_of(ch_level, 2'(c))) -
            13'(ch_of(hist_q[lag_index(shift)], 2'(c))), dac_q[c], diff_mode);
        end else begin
          hold_q[c] <= front_end(13'(ch_of(ch_level, 2'(c))), dac_q[c], diff_mode);
        end
      end
    end
  end

  // Multiplexer sequencing state
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= CCDSM_IDLE;
      seq_q <= 2'b00;
    end else if (capture) begin
      state_q <= CCDSM_RUN;
      seq_q <= 2'b00;
    end else if (conv_en) begin
      case (state_q)
        CCDSM_IDLE: begin
          seq_q <= 2'b00;
        end
        CCDSM_RUN: begin
          if (mode == CCDSM_COLOR) begin
            // Three slots per pixel, then wait for the next pulse
            if (seq_q == CCDSM_LAST_COLOR) begin
              state_q <= CCDSM_IDLE;
            end
            seq_q <= seq_q + 2'b01;
          end else if (cds) begin
            // Mono double sampling gives one result per pulse
            state_q <= CCDSM_IDLE;
            seq_q <= 2'b01;
          end else begin
            // Plain mono keeps streaming until the next pulse
            seq_q <= 2'b01;
          end
        end
        default: begin
          state_q <= CCDSM_IDLE;
          seq_q <= 2'b00;
        end
      endcase
    end
  end

  // Converter request: held sample first, live input after in plain mono
  always_comb begin
    req = '0;
    req.valid = conv_en & (state_q == CCDSM_RUN);
    if (mode == CCDSM_COLOR) begin
      req.chan = seq_q;
      req.level = hold_q[seq_q];
    end else begin
      req.chan = mono_ch;
      if (seq_q == 2'b00) begin
        req.level = hold_q[mono_ch];
      end else begin
        req.level = front_end(13'(ch_of(ch_level, mono_ch)), dac_q[mono_ch], diff_mode);
      end
    end
  end

  ccdsm_converter u_conv (
    .clk(clk),
    .rst(rst),
    .conv_en(conv_en),
    .standby(standby),
    .invert(invert),
    .req(req),
    .res(res)
  );

  // Registered data outputs
  assign conv_code = res.code;
  assign conv_chan = res.chan;
  assign conv_valid = res.valid;

  // Last result and running count, visible to software
  always_ff @(posedge clk) begin
    if (rst) begin
      last_code_q <= 12'h000;
      conv_cnt_q <= 16'h0000;
    end else if (res.valid) begin
      last_code_q <= res.code;
      conv_cnt_q <= conv_cnt_q + 16'h0001;
    end
  end

  // APB: zero wait states, error on unmapped addresses
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  always_comb begin
    case (paddr)
      CCDSM_A_S1W1, CCDSM_A_S1W2, CCDSM_A_S2W1, CCDSM_A_S2W2,
      CCDSM_A_DAC_R, CCDSM_A_DAC_G, CCDSM_A_DAC_B, CCDSM_A_CTRL,
      CCDSM_A_STATUS, CCDSM_A_LAST: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Setup register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      s1w1_q <= CCDSM_S1W1_RST;
      s1w2_q <= CCDSM_S1W2_RST;
      s2w1_q <= CCDSM_S2_RST;
      s2w2_q <= CCDSM_S2_RST;
    end else if (wr_en) begin
      case (paddr)
        CCDSM_A_S1W1: s1w1_q <= pwdata[7:0];
        CCDSM_A_S1W2: s1w2_q <= pwdata[7:0];
        CCDSM_A_S2W1: s2w1_q <= pwdata[7:0];
        CCDSM_A_S2W2: s2w2_q <= pwdata[7:0];
        default: s1w1_q <= s1w1_q;
      endcase
    end
  end

  // Offset DAC codes and control word
  always_ff @(posedge clk) begin
    if (rst) begin
      dac_q <= {3{CCDSM_DAC_RST}};
      ctrl_q <= CCDSM_CTRL_RST;
    end else if (wr_en) begin
      case (paddr)
        CCDSM_A_DAC_R: dac_q[0] <= pwdata[8:0];
        CCDSM_A_DAC_G: dac_q[1] <= pwdata[8:0];
        CCDSM_A_DAC_B: dac_q[2] <= pwdata[8:0];
        CCDSM_A_CTRL: ctrl_q <= pwdata[7:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Read data latched in the setup phase, stable through access
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= ~mapped;
      prdata <= 32'h0000_0000;
      if (rd_setup) begin
        case (paddr)
          CCDSM_A_S1W1: prdata <= {24'h000000, s1w1_q};
          CCDSM_A_S1W2: prdata <= {24'h000000, s1w2_q};
          CCDSM_A_S2W1: prdata <= {24'h000000, s2w1_q};
          CCDSM_A_S2W2: prdata <= {24'h000000, s2w2_q};
          CCDSM_A_DAC_R: prdata <= {23'h0, dac_q[0]};
          CCDSM_A_DAC_G: prdata <= {23'h0, dac_q[1]};
          CCDSM_A_DAC_B: prdata <= {23'h0, dac_q[2]};
          CCDSM_A_CTRL: prdata <= {24'h000000, ctrl_q};
          CCDSM_A_STATUS: prdata <= {conv_cnt_q, 7'h00, cds, mode, seq_q, state_q, standby, diff_mode};
          CCDSM_A_LAST: prdata <= {20'h00000, last_code_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : ccdsm_sequencer
`default_nettype wire

// File: dv/ccdsm_monitor.sv
// Port checker for the CCD sample and multiplex sequencer
`timescale 1ns/1ps
`default_nettype none
module ccdsm_monitor
  import ccdsm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic video_sample_pulse,
  input wire logic [1:0] conv_chan,
  input wire logic conv_valid,
  input wire logic diff_mode
);
  logic [7:0] w1_q, w2_q, s2_q, ct_q;
  logic [3:0] quiet_q;
  logic wr, color, maxm, cstart;
  logic [1:0] mch;
  // Shadow of mode settings, rebuilt from completed writes
  always_ff @(posedge clk) begin
    if (rst) begin
      w1_q <= CCDSM_S1W1_RST;
      w2_q <= CCDSM_S1W2_RST;
      s2_q <= CCDSM_S2_RST;
      ct_q <= CCDSM_CTRL_RST;
    end else if (wr) begin
      if (paddr == CCDSM_A_S1W1) w1_q <= pwdata[7:0];
      if (paddr == CCDSM_A_S1W2) w2_q <= pwdata[7:0];
      if (paddr == CCDSM_A_S2W2) s2_q <= pwdata[7:0];
      if (paddr == CCDSM_A_CTRL) ct_q <= pwdata[7:0];
    end
  end
  // Cycles since last write; results in flight may predate a change
  always_ff @(posedge clk) begin
    if (rst || wr) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end
  assign wr = psel && penable && pwrite && pready;
  assign maxm = w1_q == CCDSM_MAXMONO_CODE;
  assign color = !maxm && !w2_q[CCDSM_S1W2_MONO_BIT];
  assign cstart = video_sample_pulse && color && !w2_q[0] && !ct_q[2] && !psel;
  assign mch = (s2_q[1:0] == 2'h3) ? 2'h2 : s2_q[1:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence rgb_s;
    conv_valid && conv_chan == 2'h0 ##2 conv_valid && conv_chan == 2'h1 ##2 conv_valid && conv_chan == 2'h2;
  endsequence
  color_order_a: assert property (cstart |-> ##5 rgb_s)
    else $error("color results out of order or late");
  conv_rate_a: assert property (conv_valid |=> !conv_valid)
    else $error("two results in adjacent cycles");
  mono_chan_a: assert property (conv_valid && !color && quiet_q > 4'hc |-> conv_chan == mch)
    else $error("mono result from wrong channel");
  stby_quiet_a: assert property (ct_q[2] && $past(ct_q[2], 2) |-> !conv_valid)
    else $error("result while in standby");
  diff_sel_a: assert property (wr && paddr == CCDSM_A_CTRL |=> diff_mode == $past(pwdata[0]))
    else $error("input structure select not applied");
  maxm_stream_a: assert property (maxm && !ct_q[2] && quiet_q == 4'hf && !psel && conv_valid
    && (video_sample_pulse || $past(video_sample_pulse)) |=> !conv_valid ##1 conv_valid)
    else $error("max speed stream broken");
  unmapped_err_a: assert property (psel && !penable && paddr > CCDSM_A_LAST |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  apb_ready_a: assert property (psel && penable |-> pready && (paddr == CCDSM_A_STATUS || prdata[31:12] == 20'h0))
    else $error("access stalled or upper read bits set");
endmodule : ccdsm_monitor
bind ccdsm_sequencer ccdsm_monitor i_mon (.clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
  .pready, .pslverr, .video_sample_pulse, .conv_chan, .conv_valid, .diff_mode);
`default_nettype wire

// File: dv/ccdsm_front_model.sv
// Sensor front end and scanner timing: sample pulses and channel levels
`timescale 1ns/1ps
`default_nettype none
module ccdsm_front_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [3:0] ratio,
  input wire logic [35:0] lvl,
  output logic video_sample_pulse,
  output logic [35:0] ch_level
);
  logic [3:0] cnt_q;
  // One pulse per ratio clocks on rising edges, only while running
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt_q <= 4'h0;
      video_sample_pulse <= 1'b0;
    end else begin
      video_sample_pulse <= cnt_q == 4'h0;
      cnt_q <= (cnt_q == ratio - 4'h1) ? 4'h0 : cnt_q + 4'h1;
    end
  end
  // Levels move only with a pulse so the hold edge sees them settled
  always_ff @(posedge clk) begin
    if (rst) ch_level <= 36'h0;
    else if (run && cnt_q == 4'h0) ch_level <= lvl;
  end
endmodule : ccdsm_front_model
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the sample and multiplex sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ccdsm_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, vsp, conv_valid, diff_mode;
  logic [35:0] ch_level, lvl = 36'h12c8302bc;
  logic signed [11:0] lv [3] = '{12'sh2bc, 12'sh830, 12'sh12c};
  logic [3:0] ratio = 4'h6;
  logic [11:0] conv_code;
  logic [1:0] conv_chan;
  int n_fail = 0, cmp_count = 0;
  always #2.5 clk = ~clk;
  ccdsm_front_model i_fm (.clk, .rst, .run, .ratio, .lvl, .video_sample_pulse(vsp), .ch_level);
  ccdsm_sequencer i_dut (.clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .video_sample_pulse(vsp), .ch_level, .conv_code, .conv_chan, .conv_valid, .diff_mode);
  task report_and_stop();
    $display("n_fail=%0d cmp_count=%0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task tmo(input int n);
    if (n >= 100) begin
      n_fail++;
      $display("[ERR] %0t wait ran out", $time);
      report_and_stop();
    end
  endtask : tmo
  // Setup cycle, then access until pready is seen at an edge
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 100);
    tmo(n);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task grab(output logic [11:0] c, output logic [1:0] ch);
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (conv_valid !== 1'b1 && n < 100);
    tmo(n);
    c = conv_code;
    ch = conv_chan;
  endtask : grab
  // Pulses stop before a mode change so no pixel straddles it
  task setm(input logic [7:0] w1, w2, s2, ct, input logic [3:0] rt);
    run <= 1'b0;
    repeat (12) @(posedge clk);
    apb(CCDSM_A_S1W1, 1'b1, {24'h0, w1});
    apb(CCDSM_A_S1W2, 1'b1, {24'h0, w2});
    apb(CCDSM_A_S2W2, 1'b1, {24'h0, s2});
    apb(CCDSM_A_CTRL, 1'b1, {24'h0, ct});
    ratio <= rt;
    run <= 1'b1;
  endtask : setm
  function automatic logic [11:0] exp_code(input logic signed [11:0] x, input logic dif, input logic [8:0] dac,
    input logic inv);
    int v;
    v = (dif ? 1 : 2) * int'(x) + (dac[8] ? -8 : 8) * int'(dac[7:0]) + 2048;
    if (v < 0) v = 0;
    if (v > 4095) v = 4095;
    return inv ? ~v[11:0] : v[11:0];
  endfunction : exp_code
  task t_regs();
    apb(CCDSM_A_S1W2, 1'b0, 32'h0);
    chk({er, rd[30:0]}, 32'h80);
    apb(CCDSM_A_CTRL, 1'b1, 32'h1);
    apb(CCDSM_A_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, diff_mode}, 32'h1);
    apb(8'h28, 1'b1, 32'hff);
    chk({31'h0, er}, 32'h1);
    apb(8'h28, 1'b0, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(CCDSM_A_CTRL, 1'b1, 32'h0);
    $display("done registers");
  endtask : t_regs
  task t_color(input logic [7:0] ct, input logic [8:0] dac);
    logic [11:0] c;
    logic [1:0] ch;
    apb(CCDSM_A_DAC_R, 1'b1, {23'h0, dac});
    setm(8'h00, 8'h80, 8'h00, ct, 4'h6);
    for (int i = 0; i < 6; i++) begin
      grab(c, ch);
      chk({30'h0, ch}, 32'(i % 3));
      chk({20'h0, c}, {20'h0, exp_code(lv[i % 3], ct[0], (i % 3 == 0) ? dac : 9'h000, ct[1])});
    end
    $display("done color ctrl=%h dac=%h", ct, dac);
  endtask : t_color
  task t_mono();
    logic [11:0] c;
    logic [1:0] ch;
    apb(CCDSM_A_DAC_R, 1'b1, 32'h0);
    for (int s = 0; s < 4; s++) begin
      setm(8'h00, 8'h90, 8'(s), 8'h00, 4'h6);
      repeat (5) grab(c, ch);
      chk({30'h0, ch}, (s == 3) ? 32'h2 : 32'(s));
      chk({20'h0, c}, {20'h0, exp_code(lv[(s == 3) ? 2 : s], 1'b0, 9'h000, 1'b0)});
    end
    // Steady levels: video minus reset level is zero, so mid code
    setm(8'h00, 8'h91, 8'h00, 8'h00, 4'h6);
    repeat (2) grab(c, ch);
    chk({20'h0, c}, {20'h0, exp_code(12'sh000, 1'b0, 9'h000, 1'b0)});
    $display("done mono");
  endtask : t_mono
  // Rows: setup1 word1, word2, ctrl, pulse ratio, results in 30 clocks
  task t_rate();
    int n;
    logic [35:0] rows [7] = '{36'h00800060f, 36'h00811060f, 36'h00900060f, 36'h009120605,
      36'h00913030a, 36'h5d910020f, 36'h008004600};
    for (int r = 0; r < 7; r++) begin
      setm(rows[r][35:28], rows[r][27:20], 8'h00, rows[r][19:12], rows[r][11:8]);
      repeat (16) @(posedge clk);
      n = 0;
      repeat (30) begin @(posedge clk); n += (conv_valid === 1'b1); end
      chk(n, {24'h0, rows[r][7:0]});
    end
    $display("done rates");
  endtask : t_rate
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_color(8'h00, 9'h000);
    t_color(8'h03, 9'h17f);
    t_color(8'h00, 9'h07f);
    t_mono();
    t_rate();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
